// ==== verilog/netid_pkg.sv ====
/*
 * constants for the radio network parameter derivation block.
 * assumes a single clock domain and an 8-bit arithmetic datapath.
 */
package netid_pkg;
	localparam int unsigned ID_BYTES = 4;
	localparam logic [6:0] NUM_CHANNELS = 7'h4e; // 78 channels
	localparam logic [2:0] NUM_SUBSETS = 3'h6;
	localparam logic [3:0] CHANNELS_PER_SUBSET = 4'hd; // 13
	localparam logic [3:0] NUM_PN_CODES = 4'ha; // 10
	localparam logic [7:0] SUBSET_MASK = 8'h03;
	localparam logic [7:0] MIN_SUBSET = 8'h02;
	localparam logic [7:0] MAX_SUBSET = 8'h05;
	localparam int unsigned PN_SHIFT = 2;
	localparam int unsigned CH_SHIFT_R = 2;
	localparam int unsigned CH_SHIFT_L = 5;
	localparam int unsigned SEED_SHIFT = 6;
	localparam logic [7:0] UNBOUND_SEED = 8'h00;
	localparam logic [7:0] ZERO_SEED_SUB = 8'h01;
	localparam logic [2:0] SOP_THRESHOLD = 3'h4;
	localparam logic [2:0] DATA_THRESHOLD = 3'h4;
	localparam logic [3:0] BIND_PN_INDEX = 4'h0;
	localparam logic [6:0] BIND_BASE_CHANNEL = 7'h00;
	localparam logic [7:0] BIND_SUBSET = 8'h02;
	// arbitrary neutral factory identifier of this radio
	localparam logic [31:0] OWN_FACTORY_ID = 32'h1234_5678;
	typedef enum logic {CHIP32, CHIP64} pn_len_t;
	typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_WAIT_ACK} tx_state_t;
endpackage

// ==== verilog/netid_if.sv ====
/*
 * carries derived network parameters from the calculator to the top.
 * assumes both ends share clk_in.
 */
`timescale 1ns/1ps
`default_nettype none
interface netid_if;
	logic [31:0] factory_id;
	logic [3:0] pn_index;
	logic [6:0] base_channel;
	logic [7:0] subset;
	logic [7:0] crc_seed;
	modport calc (input factory_id, output pn_index, base_channel, subset, crc_seed);
	modport user (output factory_id, input pn_index, base_channel, subset, crc_seed);
endinterface
`default_nettype wire

// ==== verilog/netid_calc.sv ====
/*
 * combinational derivation of network parameters from a factory identifier.
 * assumes the identifier is stable while results are consumed.
 */
`timescale 1ns/1ps
`default_nettype none
module netid_calc
	import netid_pkg::*;
(
	netid_if.calc nif
);
	logic [7:0] b1;
	logic [7:0] b2;
	logic [7:0] b3;
	logic [7:0] pn_sum;
	logic [7:0] ch_sum;
	logic [7:0] sub_sum;
	logic [7:0] seed_sum;

	// byte 1..3 of the identifier, byte 0 the lowest
	assign b1 = nif.factory_id[15:8];
	assign b2 = nif.factory_id[23:16];
	assign b3 = nif.factory_id[31:24];

	// 8-bit wrapping sums before each modulo
	assign pn_sum = 8'((b1 << PN_SHIFT) + b2 + b3);
	assign ch_sum = 8'((b2 >> CH_SHIFT_R) - (b1 << CH_SHIFT_L) + b3);
	assign sub_sum = 8'(((b1 - b2) & SUBSET_MASK) + MIN_SUBSET);
	assign seed_sum = 8'((b2 >> SEED_SHIFT) + b1 + b3);

	// modulo steps and zero seed substitution
	assign nif.pn_index = 4'(pn_sum % 8'(NUM_PN_CODES));
	assign nif.base_channel = 7'(ch_sum % 8'(NUM_CHANNELS));
	assign nif.subset = 8'(sub_sum % 8'(NUM_CHANNELS));
	assign nif.crc_seed = (seed_sum == 8'h00) ? ZERO_SEED_SUB : seed_sum;
endmodule
`default_nettype wire

// ==== verilog/netid_top.sv ====
/*
 * radio network parameter unit: holds the bridge identifier, derives the
 * network parameters, selects bind or network parameters, hops within the
 * channel subset and sequences automatic acknowledgment and power down.
 * assumes the radio core reports valid packets and acks as one-cycle pulses.
 */
// Operation
// - 78 channels in 6 subsets of 13
// - binding uses reserved bind parameter set
// - peers need identical PN code and channel
// - PN codes of 32 or 64 chips
// - start_of_packet and data thresholds both 4
// - acknowledge every valid packet automatically
// - device powers down after ack received
// - subset number 2 to 5 selects subset
// - PN field indexes one of 10 codes
// - seed zero unbound, network seed bound
// - hold own identifier, store bridge identifier
// - connect request carries bridge identifier
// - derive all parameters from bridge identifier
// - PN index formula modulo 10
// - base channel formula modulo 78
// - subset number formula modulo 78
// - seed formula, zero becomes one
`timescale 1ns/1ps
`default_nettype none
module netid_top
	import netid_pkg::*;
(
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic is_bridge_in,
	input wire logic bind_mode_in,
	input wire logic bound_in,
	input wire logic long_range_in,
	input wire logic store_id_in,
	input wire logic [31:0] bind_id_in,
	input wire logic next_channel_in,
	input wire logic rx_valid_in,
	input wire logic [31:0] rx_connect_id_in,
	input wire logic rx_connect_in,
	input wire logic tx_start_in,
	input wire logic ack_rx_in,
	output logic [31:0] own_id_out,
	output logic [31:0] peer_id_out,
	output logic [3:0] pn_index_out,
	output logic pn_long_out,
	output logic [6:0] channel_out,
	output logic [7:0] subset_out,
	output logic [7:0] crc_seed_out,
	output logic [2:0] sop_threshold_out,
	output logic [2:0] data_threshold_out,
	output logic ack_tx_out,
	output logic connect_ok_out,
	output logic radio_on_out
);
	typedef struct packed {
		logic [31:0] peer_id;
		logic [3:0] pn_index;
		logic pn_long;
		logic [6:0] channel;
		logic [7:0] subset;
		logic [7:0] crc_seed;
		logic [3:0] hop;
		logic ack_tx;
		logic connect_ok;
		logic radio_on;
		tx_state_t tx_state;
		logic [31:0] own_id;
		logic [2:0] sop_thr;
		logic [2:0] data_thr;
	} state_t;

	state_t st_r;
	state_t st_nxt;
	netid_if nif ();

	// channel hop steps of 6 from the base within the subset, wrapping at 78
	function automatic logic [6:0] hop_channel(input logic [6:0] base, input logic [3:0] hop, input logic [7:0] sub);
		logic [10:0] sum;
		sum = 11'(base) + 11'(hop) * 11'(NUM_SUBSETS) + 11'(sub);
		return 7'(sum % 11'(NUM_CHANNELS));
	endfunction

	// network parameters come from the bridge identifier on both ends
	assign nif.factory_id = is_bridge_in ? OWN_FACTORY_ID : st_r.peer_id;

	netid_calc u_calc (
		.nif(nif)
	);

	// next state of parameter selection, hopping and transactions
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.ack_tx = 1'b0;
		// fixed identifier and correlator thresholds, registered so outputs come from flops
		st_nxt.own_id = OWN_FACTORY_ID;
		st_nxt.sop_thr = SOP_THRESHOLD;
		st_nxt.data_thr = DATA_THRESHOLD;
		st_nxt.pn_long = (long_range_in == 1'b1);
		// bridge identifier kept after binding
		if (store_id_in && !is_bridge_in)
		begin
			st_nxt.peer_id = bind_id_in;
		end
		// hop counter walks the 13 channels of the subset
		if (next_channel_in)
		begin
			st_nxt.hop = (st_r.hop == CHANNELS_PER_SUBSET - 4'h1) ? 4'h0 : st_r.hop + 4'h1;
		end
		// reserved bind set or derived network set
		if (bind_mode_in)
		begin
			st_nxt.pn_index = BIND_PN_INDEX;
			st_nxt.subset = BIND_SUBSET;
			st_nxt.channel = hop_channel(BIND_BASE_CHANNEL, st_r.hop, BIND_SUBSET);
		end
		else
		begin
			st_nxt.pn_index = nif.pn_index;
			st_nxt.subset = nif.subset;
			st_nxt.channel = hop_channel(nif.base_channel, st_r.hop, nif.subset);
		end
		// unbound traffic uses the zero seed
		st_nxt.crc_seed = (bound_in && !bind_mode_in) ? nif.crc_seed : UNBOUND_SEED;
		// ack every valid packet without firmware
		st_nxt.ack_tx = rx_valid_in;
		// bridge checks the identifier in a connect request
		if (rx_connect_in && is_bridge_in)
		begin
			st_nxt.connect_ok = (rx_connect_id_in == OWN_FACTORY_ID);
		end
		// device transmit transaction ends with automatic power down on the peer ack; a bridge's ends with the radio still on
		unique case (st_r.tx_state)
			TX_IDLE:
			begin
				if (tx_start_in)
				begin
					st_nxt.radio_on = 1'b1;
					st_nxt.tx_state = TX_SEND;
				end
			end
			TX_SEND:
			begin
				st_nxt.tx_state = TX_WAIT_ACK;
			end
			TX_WAIT_ACK:
			begin
				// a bridge keeps its radio on, so it leaves the transaction at once
				if (is_bridge_in)
				begin
					st_nxt.tx_state = TX_IDLE;
				end
				else if (ack_rx_in)
				begin
					st_nxt.radio_on = 1'b0;
					st_nxt.tx_state = TX_IDLE;
				end
			end
		endcase
	end

	// state register
	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			st_r <= '{peer_id: 32'h0000_0000, pn_index: BIND_PN_INDEX, pn_long: 1'b0,
				channel: BIND_BASE_CHANNEL, subset: BIND_SUBSET, crc_seed: UNBOUND_SEED,
				hop: 4'h0, ack_tx: 1'b0, connect_ok: 1'b0, radio_on: 1'b0, tx_state: TX_IDLE,
				own_id: OWN_FACTORY_ID, sop_thr: SOP_THRESHOLD, data_thr: DATA_THRESHOLD};
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// outputs straight from the state register
	assign own_id_out = st_r.own_id;
	assign peer_id_out = st_r.peer_id;
	assign pn_index_out = st_r.pn_index;
	assign pn_long_out = st_r.pn_long;
	assign channel_out = st_r.channel;
	assign subset_out = st_r.subset;
	assign crc_seed_out = st_r.crc_seed;
	assign sop_threshold_out = st_r.sop_thr;
	assign data_threshold_out = st_r.data_thr;
	assign ack_tx_out = st_r.ack_tx;
	assign connect_ok_out = st_r.connect_ok;
	assign radio_on_out = st_r.radio_on;
endmodule
`default_nettype wire

// ==== test/netid_top_sva.sv ====
/* port assertions for the network parameter unit.
   assumes one clock and an async active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module netid_top_sva (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic is_bridge_in,
	input wire logic bind_mode_in,
	input wire logic bound_in,
	input wire logic long_range_in,
	input wire logic rx_valid_in,
	input wire logic tx_start_in,
	input wire logic ack_rx_in,
	input wire logic [3:0] pn_index_out,
	input wire logic pn_long_out,
	input wire logic [6:0] channel_out,
	input wire logic [7:0] subset_out,
	input wire logic [7:0] crc_seed_out,
	input wire logic [2:0] sop_threshold_out,
	input wire logic [2:0] data_threshold_out,
	input wire logic ack_tx_out,
	input wire logic radio_on_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	// device transmit: start, two cycles without the peer ack, then the ack
	sequence s_tx;
		tx_start_in && !is_bridge_in ##1 !ack_rx_in [*2] ##1 ack_rx_in;
	endsequence
	chk_ack_after_rx: assert property (rx_valid_in |=> ack_tx_out) else $error("no ack");
	chk_ack_single: assert property (!rx_valid_in |=> !ack_tx_out) else $error("stray ack");
	chk_radio_wakes: assert property (tx_start_in && !is_bridge_in |=> radio_on_out) else $error("no wake");
	chk_radio_sleeps: assert property (s_tx |=> !radio_on_out) else $error("no sleep");
	chk_threshold_four: assert property (sop_threshold_out == 3'h4 && data_threshold_out == 3'h4)
		else $error("thresholds");
	chk_pn_range: assert property (pn_index_out < 4'ha) else $error("pn range");
	chk_subset_range: assert property (subset_out inside {[8'h02:8'h05]}) else $error("subset range");
	chk_channel_range: assert property (channel_out < 7'h4e) else $error("channel range");
	chk_seed_unbound: assert property (!bound_in |=> crc_seed_out == 8'h00) else $error("seed unbound");
	chk_seed_nonzero: assert property (bound_in && !bind_mode_in [*2] |-> crc_seed_out != 8'h00)
		else $error("seed zero");
	chk_bind_set: assert property (bind_mode_in [*2] |-> pn_index_out == 4'h0 && subset_out == 8'h02)
		else $error("bind set");
	chk_long_code: assert property ($rose(long_range_in) |=> pn_long_out) else $error("long code");
endmodule
`default_nettype wire

// ==== test/peer_node_model.sv ====
/* peer radio node: derives network parameters from the bridge id and
   acknowledges device transmissions. assumes it shares clk_in. */
`timescale 1ns/1ps
`default_nettype none
module peer_node_model
	import netid_pkg::*;
#(parameter int ACK_DLY = 1)
(
	input wire logic clk_in,
	input wire logic [31:0] bridge_id_in,
	input wire logic radio_on_in,
	output logic [3:0] pn_out,
	output logic [6:0] base_out,
	output logic [7:0] subset_out,
	output logic [7:0] seed_out,
	output logic ack_out
);
	logic [7:0] b1, b2, b3, t;
	int cnt = 0;
	logic sent = 1'h0;
	// 8-bit wrapping derivation from the bridge id
	always_comb
	begin
		b1 = bridge_id_in[15:8];
		b2 = bridge_id_in[23:16];
		b3 = bridge_id_in[31:24];
		t = (b1 << 2) + b2 + b3;
		pn_out = 4'(t % 8'h0a);
		t = (b2 >> 2) - (b1 << 5) + b3;
		base_out = 7'(t % 8'h4e);
		t = ((b1 - b2) & 8'h03) + 8'h02;
		subset_out = t % 8'h4e;
		t = (b2 >> 6) + b1 + b3;
		seed_out = (t == 8'h00) ? 8'h01 : t;
	end
	// one ack pulse per transmission after ACK_DLY cycles
	always @(posedge clk_in)
	begin
		ack_out <= 1'h0;
		if (!radio_on_in)
		begin
			cnt <= 0;
			sent <= 1'h0;
		end
		else if (!sent && cnt == ACK_DLY)
		begin
			ack_out <= 1'h1;
			sent <= 1'h1;
		end
		else if (!sent)
			cnt <= cnt + 1;
	end
endmodule
`default_nettype wire

// ==== test/tb_netid_top.sv ====
/* self-checking bench for the network parameter unit.
   assumes the package, design, peer model and checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,a) begin compares++; if ((a) !== (e)) begin bad_count++; \
	$display("mismatch %s exp %h got %h", n, e, a); end end
module tb_netid_top
	import netid_pkg::*;
;
	logic clk_in = 1'h0, resetn_in = 1'h0, is_bridge_in = 1'h0, bind_mode_in = 1'h0, bound_in = 1'h0;
	logic long_range_in = 1'h0, store_id_in = 1'h0, next_channel_in = 1'h0, rx_valid_in = 1'h0;
	logic rx_connect_in = 1'h0, tx_start_in = 1'h0, ack_rx_in, pn_long_out, ack_tx_out, connect_ok_out, radio_on_out;
	logic [31:0] bind_id_in = 32'h0, rx_connect_id_in = 32'h0, own_id_out, peer_id_out;
	logic [3:0] pn_index_out, e_pn;
	logic [6:0] channel_out, e_base, c0;
	logic [7:0] subset_out, crc_seed_out, e_sub, e_seed;
	logic [2:0] sop_threshold_out, data_threshold_out;
	logic [31:0] ids [4] = '{32'h8000_8000, 32'hffff_ff00, 32'h5a3c_c3a5, 32'h0001_0200};
	int bad_count = 0, compares = 0;
	// 50 MHz clock
	always #10 clk_in = ~clk_in;
	netid_top i_netid_top (.clk_in, .resetn_in, .is_bridge_in, .bind_mode_in, .bound_in, .long_range_in,
		.store_id_in, .bind_id_in, .next_channel_in, .rx_valid_in, .rx_connect_id_in, .rx_connect_in,
		.tx_start_in, .ack_rx_in, .own_id_out, .peer_id_out, .pn_index_out, .pn_long_out, .channel_out,
		.subset_out, .crc_seed_out, .sop_threshold_out, .data_threshold_out, .ack_tx_out, .connect_ok_out,
		.radio_on_out);
	peer_node_model i_peer_node_model (.clk_in, .bridge_id_in(is_bridge_in ? OWN_FACTORY_ID : bind_id_in),
		.radio_on_in(radio_on_out), .pn_out(e_pn), .base_out(e_base), .subset_out(e_sub), .seed_out(e_seed),
		.ack_out(ack_rx_in));
	task automatic step(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	task automatic tally_and_finish();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic t_params();
		`CHK("pn", e_pn, pn_index_out)
		`CHK("subset", e_sub, subset_out)
		`CHK("seed", e_seed, crc_seed_out)
	endtask
	task automatic t_derive();
		@(posedge clk_in) bound_in <= 1'h1;
		foreach (ids[i])
		begin
			@(posedge clk_in) bind_id_in <= ids[i];
			store_id_in <= 1'h1;
			@(posedge clk_in) store_id_in <= 1'h0;
			step(3);
			`CHK("peer", ids[i], peer_id_out)
			t_params();
			`CHK("channel", (e_base + e_sub) % 8'h4e, channel_out)
		end
		$display("t_derive done");
	endtask
	task automatic t_hop();
		c0 = channel_out;
		@(posedge clk_in) next_channel_in <= 1'h1;
		@(posedge clk_in) next_channel_in <= 1'h0;
		step(1);
		`CHK("hop", (c0 + 8'h06) % 8'h4e, channel_out)
		repeat (12) @(posedge clk_in) next_channel_in <= 1'h1;
		@(posedge clk_in) next_channel_in <= 1'h0;
		step(1);
		`CHK("wrap", c0, channel_out)
		$display("t_hop done");
	endtask
	task automatic t_bind();
		@(posedge clk_in) bind_mode_in <= 1'h1;
		bound_in <= 1'h0;
		step(3);
		`CHK("bind pn", 4'h0, pn_index_out)
		`CHK("bind subset", 8'h02, subset_out)
		`CHK("bind seed", 8'h00, crc_seed_out)
		@(posedge clk_in) bind_mode_in <= 1'h0;
		$display("t_bind done");
	endtask
	task automatic t_radio();
		@(posedge clk_in) rx_valid_in <= 1'h1;
		long_range_in <= 1'h1;
		@(posedge clk_in) rx_valid_in <= 1'h0;
		#1;
		`CHK("ack", 1'h1, ack_tx_out)
		`CHK("long", 1'h1, pn_long_out)
		step(1);
		`CHK("ack end", 1'h0, ack_tx_out)
		@(posedge clk_in) tx_start_in <= 1'h1;
		@(posedge clk_in) tx_start_in <= 1'h0;
		#1;
		`CHK("radio on", 1'h1, radio_on_out)
		for (int i = 0; i < 10 && radio_on_out !== 1'h0; i++)
			step(1);
		`CHK("radio off", 1'h0, radio_on_out)
		if (radio_on_out !== 1'h0)
			tally_and_finish();
		$display("t_radio done");
	endtask
	task automatic t_connect(input logic [31:0] id, input logic ok);
		@(posedge clk_in) is_bridge_in <= 1'h1;
		bound_in <= 1'h1;
		rx_connect_id_in <= id;
		rx_connect_in <= 1'h1;
		@(posedge clk_in) rx_connect_in <= 1'h0;
		step(3);
		`CHK("connect", ok, connect_ok_out)
		t_params();
		$display("t_connect done");
	endtask
	// main sequence
	initial
	begin
		step(12);
		`CHK("reset seed", 8'h00, crc_seed_out)
		`CHK("reset subset", 8'h02, subset_out)
		@(posedge clk_in) resetn_in <= 1'h1;
		step(1);
		`CHK("own id", OWN_FACTORY_ID, own_id_out)
		`CHK("sop thr", 3'h4, sop_threshold_out)
		`CHK("data thr", 3'h4, data_threshold_out)
		t_derive();
		t_hop();
		t_bind();
		t_radio();
		t_connect(OWN_FACTORY_ID, 1'h1);
		t_connect(~OWN_FACTORY_ID, 1'h0);
		tally_and_finish();
	end
endmodule
bind netid_top netid_top_sva i_netid_top_sva (.clk_in, .resetn_in, .is_bridge_in, .bind_mode_in, .bound_in,
	.long_range_in, .rx_valid_in, .tx_start_in, .ack_rx_in, .pn_index_out, .pn_long_out, .channel_out,
	.subset_out, .crc_seed_out, .sop_threshold_out, .data_threshold_out, .ack_tx_out, .radio_on_out);
`default_nettype wire
